// ---- include/udc_defines.svh ----
// udc_defines.svh: widths, count limits and phase lengths of the up/down counter pair
// assumes: included by the package and by both counter ends
`ifndef UDC_DEFINES_SVH
`define UDC_DEFINES_SVH

// counter width and characteristic states
`define UDC_W 4
`define UDC_ZERO 4'h0
`define UDC_BIN_MAX 4'hf
`define UDC_DEC_MAX 4'h9

// reset levels of the link lines
`define UDC_CLK_IDLE 1'b1
`define UDC_LOAD_IDLE 1'b1
`define UDC_CLEAR_IDLE 1'b0

// driving end phase lengths, in clk_i cycles, and the phase counter width in bits
`define UDC_LOW_CYC 4
`define UDC_HIGH_CYC 4
`define UDC_HOLD_CYC 2
`define UDC_GAP_CYC 2
`define UDC_CNT_W 4

`endif

// ---- include/udc_pkg.sv ----
// udc_pkg.sv: types shared by the counter end, the driving end and the link
// assumes: udc_defines.svh is on the include path
`include "udc_defines.svh"

package udc_pkg;

    typedef logic [`UDC_W-1:0] udc_cnt_t;

    // requests of the driving end
    typedef enum logic [1:0] {UDC_OP_UP, UDC_OP_DOWN, UDC_OP_LOAD, UDC_OP_CLEAR} udc_op_e;

    // feedback wiring chosen at the driving end
    typedef enum logic [1:0] {UDC_MODE_FREE, UDC_MODE_LIMIT, UDC_MODE_DIVIDE} udc_mode_e;

    // driving end sequencer
    typedef enum logic [2:0] {UDC_ST_IDLE, UDC_ST_LOW, UDC_ST_STROBE, UDC_ST_GAP} udc_state_e;

    // edge sampler state
    typedef struct packed {
        logic last;
    } udc_edge_s;

    // counter end state
    typedef struct packed {
        udc_cnt_t count;
        logic up_term_n;
        logic down_term_n;
    } udc_dev_s;

    // driving end state
    typedef struct packed {
        udc_state_e state;
        logic [`UDC_CNT_W-1:0] cnt;
        logic up_clk;
        logic down_clk;
        logic load_n;
        logic clear;
        udc_cnt_t preset;
        logic pin_load_n;
        logic pin_clear;
        udc_cnt_t pin_preset;
        logic ready;
        udc_cnt_t seen;
    } udc_drv_s;

endpackage

// ---- include/udc_if.sv ----
// udc_if.sv: link between the counter and the logic that drives it
// assumes: both ends share clk_i; the testbench instantiates and joins them
`timescale 1ns/10ps

interface udc_if;
    import udc_pkg::*;

    // count clocks, idle high
    logic up_count_clock;
    logic down_count_clock;
    // preset and clear
    logic preset_strobe_n;
    logic clear_input;
    udc_cnt_t preset_bits;
    // counter state and terminal outputs
    udc_cnt_t count;
    logic up_terminal_out_n;
    logic down_terminal_out_n;

    modport dev (
        input up_count_clock,
        input down_count_clock,
        input preset_strobe_n,
        input clear_input,
        input preset_bits,
        output count,
        output up_terminal_out_n,
        output down_terminal_out_n
    );

    modport drv (
        output up_count_clock,
        output down_count_clock,
        output preset_strobe_n,
        output clear_input,
        output preset_bits,
        input count,
        input up_terminal_out_n,
        input down_terminal_out_n
    );
endinterface

// ---- core/udc_edge.sv ----
// udc_edge.sv: low-to-high detector for one count clock line
// assumes: the line is synchronous to clk_i
`timescale 1ns/10ps
`include "udc_defines.svh"

module udc_edge
    import udc_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // sampled line and its rising edge
    input wire logic line_i,
    output logic rise_o
);
    import udc_pkg::*;

    udc_edge_s s_ff;
    udc_edge_s nxt_s;

    // remember the level seen this cycle
    always_comb
    begin
        nxt_s = s_ff;
        nxt_s.last = line_i;
    end

    // idle level is high, so no rise is seen out of reset
    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            s_ff <= '{last: `UDC_CLK_IDLE};
        end
        else
        begin
            s_ff <= nxt_s;
        end
    end

    // a rise is a high now after a low last cycle
    assign rise_o = line_i & ~s_ff.last;
endmodule

// ---- core/udc_counter.sv ----
// udc_counter.sv: dual count clock up/down counter, decade or binary
// assumes: all link inputs are synchronous to clk_i; one clk_i domain
// assumes: the driving end keeps load and clear releases apart
`timescale 1ns/10ps
`include "udc_defines.svh"

// Contract
// - four bits, decade or binary sequence
// - count only on a count clock rise
// - driver pulses one clock, other held high
// - driver never holds both clocks low
// - all four bits change together
// - binary bits toggle by lower-bit steering
// - load low, clear low: preset copied
// - load release keeps preset, counting resumes
// - load high ignores preset inputs
// - clear high zeroes count, beats all
// - load and clear never released together
// - up terminal low: up clock low, max
// - down terminal low: down clock low, zero
// - terminals clock the next stage
// - terminals follow count after clear, preset
// - divider: down terminal drives load
// - decade up terminal on state nine
// - limited range: no wrap either way
// - limits via clear and load feedback
module udc_counter
    import udc_pkg::*;
#(
    parameter bit DECADE = 1'b0
)
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // link to the driving logic
    udc_if.dev link,
    // user side view of the count
    output udc_pkg::udc_cnt_t count_o
);
    import udc_pkg::*;

    localparam udc_cnt_t TOP = DECADE ? `UDC_DEC_MAX : `UDC_BIN_MAX;

    // state register and count clock rise strobes
    udc_dev_s s_ff;
    udc_dev_s nxt_s;
    logic up_rise;
    logic down_rise;

    // highest state of the chosen variant
    function automatic logic at_top(input udc_cnt_t c);
        at_top = (c == TOP);
    endfunction

    // active low terminal: clock line low while the count sits on its end state
    function automatic logic term_n(input logic clk_line, input logic hit);
        term_n = ~(~clk_line & hit);
    endfunction

    // binary steering: a bit toggles when all lower bits agree with direction
    function automatic udc_cnt_t bin_step(input udc_cnt_t c, input logic up);
        logic carry;
        udc_cnt_t r;
        carry = 1'b1;
        r = c;
        for (int i = 0; i < `UDC_W; i++)
        begin
            r[i] = c[i] ^ carry;
            carry = carry & (up ? c[i] : ~c[i]);
        end
        bin_step = r;
    endfunction

    // decade up sequence; codes above nine fall back into the loop
    function automatic udc_cnt_t dec_up(input udc_cnt_t c);
        case (c)
            4'h0: dec_up = 4'h1;
            4'h1: dec_up = 4'h2;
            4'h2: dec_up = 4'h3;
            4'h3: dec_up = 4'h4;
            4'h4: dec_up = 4'h5;
            4'h5: dec_up = 4'h6;
            4'h6: dec_up = 4'h7;
            4'h7: dec_up = 4'h8;
            4'h8: dec_up = 4'h9;
            4'h9: dec_up = 4'h0;
            4'ha: dec_up = 4'hb;
            4'hb: dec_up = 4'h0;
            4'hc: dec_up = 4'hd;
            4'hd: dec_up = 4'h0;
            4'he: dec_up = 4'hf;
            4'hf: dec_up = 4'h0;
            default: dec_up = 4'h0;
        endcase
    endfunction

    // decade down sequence; codes above nine walk down to nine
    function automatic udc_cnt_t dec_down(input udc_cnt_t c);
        case (c)
            4'h0: dec_down = 4'h9;
            4'h1: dec_down = 4'h0;
            4'h2: dec_down = 4'h1;
            4'h3: dec_down = 4'h2;
            4'h4: dec_down = 4'h3;
            4'h5: dec_down = 4'h4;
            4'h6: dec_down = 4'h5;
            4'h7: dec_down = 4'h6;
            4'h8: dec_down = 4'h7;
            4'h9: dec_down = 4'h8;
            4'ha: dec_down = 4'h9;
            4'hb: dec_down = 4'ha;
            4'hc: dec_down = 4'hb;
            4'hd: dec_down = 4'hc;
            4'he: dec_down = 4'hd;
            4'hf: dec_down = 4'he;
            default: dec_down = 4'h9;
        endcase
    endfunction

    // next state of the sequence for one direction
    // both variants share priority and terminal logic
    function automatic udc_cnt_t step(input udc_cnt_t c, input logic up);
        if (DECADE)
        begin
            step = up ? dec_up(c) : dec_down(c);
        end
        else
        begin
            step = bin_step(c, up);
        end
    endfunction

    // rising edge of each count clock
    udc_edge u_up_edge (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .line_i(link.up_count_clock),
        .rise_o(up_rise)
    );

    udc_edge u_down_edge (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .line_i(link.down_count_clock),
        .rise_o(down_rise)
    );

    // count, preset and clear, then terminal decode from the new count
    // priority: clear, then load, then a single clock rise
    // a rise that meets clear or load is dropped, not remembered
    always_comb
    begin
        nxt_s = s_ff;
        if (link.clear_input)
        begin
            nxt_s.count = `UDC_ZERO;
        end
        else if (!link.preset_strobe_n)
        begin
            nxt_s.count = link.preset_bits;
        end
        else if (up_rise && !down_rise)
        begin
            // preset bits are not looked at on this path
            nxt_s.count = step(s_ff.count, 1'b1);
        end
        else if (down_rise && !up_rise)
        begin
            nxt_s.count = step(s_ff.count, 1'b0);
        end
        else
        begin
            // no edge, or both at once: hold
            nxt_s.count = s_ff.count;
        end
        // terminals track the new count and the present clock level
        // registered, so they follow a clock fall one clk_i cycle later
        nxt_s.up_term_n = term_n(link.up_count_clock, at_top(nxt_s.count));
        nxt_s.down_term_n = term_n(link.down_count_clock, nxt_s.count == `UDC_ZERO);
    end

    // all bits of the count move on one clk_i edge
    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            // zero count, both terminals released
            s_ff <= '{
                count: `UDC_ZERO,
                up_term_n: 1'b1,
                down_term_n: 1'b1
            };
        end
        else
        begin
            s_ff <= nxt_s;
        end
    end

    // outputs straight from the state flops
    assign link.count = s_ff.count;
    assign link.up_terminal_out_n = s_ff.up_term_n;
    assign link.down_terminal_out_n = s_ff.down_term_n;
    assign count_o = s_ff.count;
endmodule

// ---- core/udc_driver.sv ----
// udc_driver.sv: logic that clocks, loads and clears the counter
// assumes: counter end on the same clk_i; one request at a time
`timescale 1ns/10ps
`include "udc_defines.svh"

module udc_driver
    import udc_pkg::*;
#(
    parameter bit DECADE = 1'b0,
    parameter int LOW_CYC = `UDC_LOW_CYC,
    parameter int HIGH_CYC = `UDC_HIGH_CYC,
    parameter int HOLD_CYC = `UDC_HOLD_CYC,
    parameter int GAP_CYC = `UDC_GAP_CYC
)
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // feedback wiring
    input wire udc_pkg::udc_mode_e mode_i,
    // request
    input wire logic cmd_valid_i,
    input wire udc_pkg::udc_op_e cmd_op_i,
    input wire udc_pkg::udc_cnt_t cmd_data_i,
    output logic cmd_ready_o,
    // observed count
    output udc_pkg::udc_cnt_t count_o,
    // link to the counter
    udc_if.drv link
);
    import udc_pkg::*;

    localparam udc_cnt_t TOP = DECADE ? `UDC_DEC_MAX : `UDC_BIN_MAX;

    udc_drv_s s_ff;
    udc_drv_s nxt_s;

    // phase counter preload
    function automatic logic [`UDC_CNT_W-1:0] len(input int n);
        len = `UDC_CNT_W'(n - 1);
    endfunction

    // request sequencer, then feedback onto the pins
    always_comb
    begin
        nxt_s = s_ff;
        nxt_s.seen = link.count;
        case (s_ff.state)
            UDC_ST_IDLE:
            begin
                if (cmd_valid_i && s_ff.ready)
                begin
                    nxt_s.ready = 1'b0;
                    case (cmd_op_i)
                        UDC_OP_UP:
                        begin
                            nxt_s.up_clk = 1'b0;
                            nxt_s.state = UDC_ST_LOW;
                            nxt_s.cnt = len(LOW_CYC);
                        end
                        UDC_OP_DOWN:
                        begin
                            nxt_s.down_clk = 1'b0;
                            nxt_s.state = UDC_ST_LOW;
                            nxt_s.cnt = len(LOW_CYC);
                        end
                        UDC_OP_LOAD:
                        begin
                            nxt_s.preset = cmd_data_i;
                            nxt_s.load_n = 1'b0;
                            nxt_s.state = UDC_ST_STROBE;
                            nxt_s.cnt = len(HOLD_CYC);
                        end
                        default:
                        begin
                            nxt_s.clear = 1'b1;
                            nxt_s.state = UDC_ST_STROBE;
                            nxt_s.cnt = len(HOLD_CYC);
                        end
                    endcase
                end
            end
            UDC_ST_LOW:
            begin
                if (s_ff.cnt == '0)
                begin
                    nxt_s.up_clk = 1'b1;
                    nxt_s.down_clk = 1'b1;
                    nxt_s.state = UDC_ST_GAP;
                    nxt_s.cnt = len(HIGH_CYC);
                end
                else
                begin
                    nxt_s.cnt = s_ff.cnt - 1'b1;
                end
            end
            UDC_ST_STROBE:
            begin
                if (s_ff.cnt == '0)
                begin
                    // only one of the two is ever active here
                    nxt_s.load_n = 1'b1;
                    nxt_s.clear = 1'b0;
                    nxt_s.state = UDC_ST_GAP;
                    nxt_s.cnt = len(GAP_CYC);
                end
                else
                begin
                    nxt_s.cnt = s_ff.cnt - 1'b1;
                end
            end
            UDC_ST_GAP:
            begin
                if (s_ff.cnt == '0)
                begin
                    nxt_s.state = UDC_ST_IDLE;
                    nxt_s.ready = 1'b1;
                end
                else
                begin
                    nxt_s.cnt = s_ff.cnt - 1'b1;
                end
            end
            default:
            begin
                nxt_s.state = UDC_ST_IDLE;
                nxt_s.ready = 1'b1;
            end
        endcase
        // lower limit: zero held by clear while down terminal is low
        nxt_s.pin_clear = nxt_s.clear | (mode_i == UDC_MODE_LIMIT && !link.down_terminal_out_n);
        // upper limit loads the top value; divider reloads the programmed value
        nxt_s.pin_load_n = nxt_s.load_n
            & ~(mode_i == UDC_MODE_LIMIT && !link.up_terminal_out_n)
            & ~(mode_i == UDC_MODE_DIVIDE && !link.down_terminal_out_n);
        nxt_s.pin_preset = (mode_i == UDC_MODE_LIMIT) ? TOP : nxt_s.preset;
    end

    // registered state and pins
    always_ff @(posedge clk_i)
    begin
        if (!rstn_i)
        begin
            s_ff <= '{state: UDC_ST_IDLE, cnt: '0, up_clk: `UDC_CLK_IDLE, down_clk: `UDC_CLK_IDLE,
                      load_n: `UDC_LOAD_IDLE, clear: `UDC_CLEAR_IDLE, preset: `UDC_ZERO,
                      pin_load_n: `UDC_LOAD_IDLE, pin_clear: `UDC_CLEAR_IDLE, pin_preset: `UDC_ZERO,
                      ready: 1'b1, seen: `UDC_ZERO};
        end
        else
        begin
            s_ff <= nxt_s;
        end
    end

    // outputs straight from flops
    assign link.up_count_clock = s_ff.up_clk;
    assign link.down_count_clock = s_ff.down_clk;
    assign link.preset_strobe_n = s_ff.pin_load_n;
    assign link.clear_input = s_ff.pin_clear;
    assign link.preset_bits = s_ff.pin_preset;
    assign cmd_ready_o = s_ff.ready;
    assign count_o = s_ff.seen;
endmodule

// ---- bench/udc_monitor.sv ----
// udc_monitor.sv: concurrent checks on the counter link
// assumes: one clk_i domain; placed by the testbench beside the first link
`timescale 1ns/10ps

module udc_monitor
    import udc_pkg::*;
#(
    parameter bit DECADE = 1'b0
)
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // driving end lines
    input wire logic up_count_clock,
    input wire logic down_count_clock,
    input wire logic preset_strobe_n,
    input wire logic clear_input,
    input wire udc_pkg::udc_cnt_t preset_bits,
    // counter end lines
    input wire udc_pkg::udc_cnt_t count,
    input wire logic up_terminal_out_n,
    input wire logic down_terminal_out_n
);
    localparam udc_cnt_t TOP = DECADE ? 4'h9 : 4'hf;

    // successor going up, illegal decade codes included
    function automatic udc_cnt_t step_up(input udc_cnt_t c);
        if (DECADE && c >= 4'h9 && c[0])
            return 4'h0;
        return c + 4'h1;
    endfunction

    // successor going down
    function automatic udc_cnt_t step_dn(input udc_cnt_t c);
        if (DECADE && c == 4'h0)
            return 4'h9;
        return c - 4'h1;
    endfunction

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    // count clock rises with neither load nor clear in force
    sequence free_up;
        !clear_input && preset_strobe_n && $rose(up_count_clock) && !$rose(down_count_clock);
    endsequence
    sequence free_dn;
        !clear_input && preset_strobe_n && $rose(down_count_clock) && !$rose(up_count_clock);
    endsequence
    // one up pulse: low four cycles, then high
    sequence up_pulse;
        !up_count_clock [*4] ##1 up_count_clock;
    endsequence

    a_clear_zero: assert property (clear_input |=> count == 4'h0)
        else $error("clear did not zero the count");
    a_load_copy: assert property (!clear_input && !preset_strobe_n |=> count == $past(preset_bits))
        else $error("load did not copy the preset bits");
    a_count_hold: assert property (!clear_input && preset_strobe_n && !$rose(up_count_clock)
        && !$rose(down_count_clock) |=> $stable(count))
        else $error("count moved without a cause");
    a_up_step: assert property (free_up |=> count == step_up($past(count)))
        else $error("wrong step on up clock");
    a_down_step: assert property (free_dn |=> count == step_dn($past(count)))
        else $error("wrong step on down clock");
    a_up_term: assert property (rstn_i |=> up_terminal_out_n == !(!$past(up_count_clock) && count == TOP))
        else $error("up terminal wrong");
    a_down_term: assert property (rstn_i |=> down_terminal_out_n == !(!$past(down_count_clock) && count == 4'h0))
        else $error("down terminal wrong");
    a_clk_exclusive: assert property (up_count_clock || down_count_clock)
        else $error("both count clocks low");
    a_release_apart: assert property (!($rose(preset_strobe_n) && $fell(clear_input)))
        else $error("load and clear released together");
    a_up_pulse: assert property ($fell(up_count_clock) |-> down_count_clock throughout up_pulse)
        else $error("up pulse shape wrong");
endmodule

// ---- bench/tb_dual_clock_updown_counter.sv ----
// tb_dual_clock_updown_counter.sv: self-checking bench, binary pair 0, decade pair 1
// assumes: package, link, both ends and udc_monitor compiled first
`timescale 1ns/10ps

module tb_dual_clock_updown_counter;
    import udc_pkg::*;

    // clock, reset, requests and observed lines
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [1:0] vld = 2'b00;
    udc_op_e op [2] = '{UDC_OP_UP, UDC_OP_UP};
    udc_cnt_t dat [2] = '{4'h0, 4'h0};
    udc_mode_e mode [2] = '{UDC_MODE_FREE, UDC_MODE_FREE};
    wire [1:0] rdy;
    wire [1:0] tu;
    wire [1:0] td;
    wire udc_cnt_t cnt [2];
    wire udc_cnt_t dcnt [2];
    int fail_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    logic t_up;
    logic t_dn;

    // 25 MHz clock
    always #20 clk_i = ~clk_i;

    // counter and driving end joined by one link per pair
    for (genvar k = 0; k < 2; k++)
    begin : g_pair
        udc_if udc_if_inst ();
        udc_counter #(.DECADE(k == 1)) udc_counter_inst (.clk_i(clk_i), .rstn_i(rstn_i),
            .link(udc_if_inst.dev), .count_o(cnt[k]));
        udc_driver #(.DECADE(k == 1)) udc_driver_inst (.clk_i(clk_i), .rstn_i(rstn_i), .mode_i(mode[k]),
            .cmd_valid_i(vld[k]), .cmd_op_i(op[k]), .cmd_data_i(dat[k]), .cmd_ready_o(rdy[k]),
            .count_o(dcnt[k]), .link(udc_if_inst.drv));
        assign tu[k] = udc_if_inst.up_terminal_out_n;
        assign td[k] = udc_if_inst.down_terminal_out_n;
    end

    // checks on the binary link
    udc_monitor #(.DECADE(1'b0)) udc_monitor_inst (.clk_i(clk_i), .rstn_i(rstn_i),
        .up_count_clock(g_pair[0].udc_if_inst.up_count_clock),
        .down_count_clock(g_pair[0].udc_if_inst.down_count_clock),
        .preset_strobe_n(g_pair[0].udc_if_inst.preset_strobe_n),
        .clear_input(g_pair[0].udc_if_inst.clear_input),
        .preset_bits(g_pair[0].udc_if_inst.preset_bits),
        .count(g_pair[0].udc_if_inst.count),
        .up_terminal_out_n(g_pair[0].udc_if_inst.up_terminal_out_n),
        .down_terminal_out_n(g_pair[0].udc_if_inst.down_terminal_out_n));

    // verdict and end of run
    task automatic test_done();
        if (fail_count == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // compare one value
    task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one request; terminals probed mid low phase, then wait for idle
    task automatic cmd(input int k, input udc_op_e o, input udc_cnt_t d);
        int n;
        n = 0;
        vld[k] = 1'b1;
        op[k] = o;
        dat[k] = d;
        @(posedge clk_i);
        #1;
        vld[k] = 1'b0;
        repeat (2) @(posedge clk_i);
        #1;
        t_up = tu[k];
        t_dn = td[k];
        while (rdy[k] !== 1'b1 && n < 40)
        begin
            @(posedge clk_i);
            #1;
            n++;
        end
        chk("ready", 4'h1, {3'h0, rdy[k]});
    endtask

    // request, then compare both views of the count
    task automatic step(input int k, input udc_op_e o, input udc_cnt_t d, input udc_cnt_t exp);
        cmd(k, o, d);
        chk("count", exp, cnt[k]);
        chk("driver_count", exp, dcnt[k]);
    endtask

    // hang guard
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 6000)
        begin
            fail_count++;
            test_done();
        end
    end

    // main sequence
    initial
    begin
        repeat (6) @(posedge clk_i);
        #1;
        rstn_i = 1'b1;
        chk("up_term", 4'h1, {3'h0, tu[0]});
        step(0, UDC_OP_LOAD, 4'he, 4'he);
        step(0, UDC_OP_UP, 4'h0, 4'hf);
        chk("up_term", 4'h1, {3'h0, t_up});
        step(0, UDC_OP_UP, 4'h0, 4'h0);
        chk("up_term", 4'h0, {3'h0, t_up});
        step(0, UDC_OP_DOWN, 4'h0, 4'hf);
        chk("down_term", 4'h0, {3'h0, t_dn});
        for (int i = 0; i < 16; i++)
            step(0, UDC_OP_UP, 4'h0, 4'(i));
        step(0, UDC_OP_CLEAR, 4'h0, 4'h0);
        for (int i = 0; i < 16; i++)
            step(0, UDC_OP_DOWN, 4'h0, 4'(15 - i));
        // limited range: no wrap either way
        mode[0] = UDC_MODE_LIMIT;
        step(0, UDC_OP_LOAD, 4'h3, 4'hf);
        step(0, UDC_OP_UP, 4'h0, 4'hf);
        step(0, UDC_OP_CLEAR, 4'h0, 4'h0);
        step(0, UDC_OP_DOWN, 4'h0, 4'h0);
        step(0, UDC_OP_UP, 4'h0, 4'h1);
        // divider: zero reloads, then the rise steps on
        mode[0] = UDC_MODE_DIVIDE;
        step(0, UDC_OP_LOAD, 4'h3, 4'h3);
        for (int i = 0; i < 3; i++)
            step(0, UDC_OP_DOWN, 4'h0, 4'(2 - i));
        step(0, UDC_OP_DOWN, 4'h0, 4'h2);
        // decade pair, legal and illegal codes
        step(1, UDC_OP_LOAD, 4'h8, 4'h8);
        step(1, UDC_OP_UP, 4'h0, 4'h9);
        step(1, UDC_OP_UP, 4'h0, 4'h0);
        chk("up_term", 4'h0, {3'h0, t_up});
        step(1, UDC_OP_DOWN, 4'h0, 4'h9);
        step(1, UDC_OP_LOAD, 4'hc, 4'hc);
        step(1, UDC_OP_UP, 4'h0, 4'hd);
        step(1, UDC_OP_UP, 4'h0, 4'h0);
        step(1, UDC_OP_LOAD, 4'ha, 4'ha);
        step(1, UDC_OP_DOWN, 4'h0, 4'h9);
        test_done();
    end
endmodule
